// File: sector_protect_command_decoder_tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench for host and device ends
// ****************************************
module sector_protect_command_decoder_tb;
  import spd_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [23:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0]  m;
  } spd_row_s;

  logic               mclk_i;
  logic               rst_i;
  logic               cmd_valid_i;
  logic               cmd_rd_i;
  logic [23:0]        cmd_addr_i;
  logic [15:0]        cmd_data_i;
  logic               cmd_ready_o;
  logic               rsp_valid_o;
  logic [15:0]        rsp_data_o;
  logic [63:0]        pers_bits_i;
  logic [63:0]        vol_bits_o;
  logic               freeze_o;
  spd_mode_e          mode_o;
  logic [15:0]        q;
  int                 miscompares;
  int                 check_count;
  spd_row_s           rows [45];

  spd_link_if #(.AW(24)) lk_if ();
  spd_dev #(.AW(24)) u_spd_dev (.mclk_i(mclk_i), .rst_i(rst_i), .lk(lk_if),
    .pers_bits_i(pers_bits_i), .mode_o(mode_o), .vol_bits_o(vol_bits_o), .freeze_o(freeze_o));
  spd_hst #(.AW(24), .HALF(4)) u_spd_hst (.mclk_i(mclk_i), .rst_i(rst_i), .lk(lk_if),
    .cmd_valid_i(cmd_valid_i), .cmd_rd_i(cmd_rd_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o));
  spd_checker #(.AW(24)) u_spd_checker (.mclk_i(mclk_i), .rst_i(rst_i), .ck(lk_if.ck),
    .cs_n(lk_if.cs_n), .rd(lk_if.rd), .addr(lk_if.addr), .wdata(lk_if.wdata),
    .rdata(lk_if.rdata), .rds(lk_if.rds));

  // Clock, 25 ns period
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Compare and count
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One user request, waits for ready and read answer
  task xfer(input logic r, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_rd_i    <= r;
    cmd_addr_i  <= a;
    cmd_data_i  <= d;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    while (r && rsp_valid_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 100) check(0, 1);
    q = rsp_data_o;
    repeat (2) @(negedge mclk_i);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 100) check(0, 1);
  endtask

  // Watchdog, about 60 transfers of some 20 clocks each, with wide margin
  initial begin
    #200000;
    miscompares++;
    conclude;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    miscompares = 0;
    check_count = 0;
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_rd_i = 1'b0;
    cmd_addr_i = 24'h000000;
    cmd_data_i = 16'h0000;
    pers_bits_i = 64'hFFFF_FFFF_FFFF_FFFD;
    rows = '{'{1,'h123,0,'hFFFF,0}, '{0,'hFFF555,'h12AA,0,0}, '{0,'h2AA,'h55,0,0},
      '{0,'h555,'h50,0,1}, '{1,'h777,0,'hFFFF,1}, '{0,0,'hA0,0,1}, '{0,'h123,0,0,1},
      '{1,'h42,0,'hFFFE,1}, '{0,0,'h90,0,1}, '{0,0,0,0,0},
      '{0,'h555,'hAA,0,0}, '{0,'h2AA,'h55,0,0}, '{0,'h555,'hE0,0,2},
      '{0,0,'hA0,0,2}, '{0,'h1812,0,0,2}, '{1,'h1805,0,'hFFFE,2},
      '{0,0,'h60,0,2}, '{1,'h1801,0,'hFFFC,2}, '{0,0,'hA0,0,2}, '{0,'h18FF,1,0,2},
      '{1,'h1800,0,'hFFFF,2}, '{0,0,'h60,0,2}, '{1,'h801,0,'hFFFA,2}, '{0,0,'hF0,0,0},
      '{0,'h555,'hAA,0,0}, '{0,'h2AA,'h55,0,0}, '{0,'h555,'h75,0,3},
      '{1,'h10,0,0,3}, '{0,0,'hF0,0,0},
      '{0,'h555,'hAA,0,0}, '{0,'h2AA,'h33,0,0}, '{0,'h2AA,'h55,0,0}, '{0,'h555,'h50,0,0},
      '{0,'h555,'hAA,0,0}, '{0,'h555,'h55,0,0}, '{0,'h555,'h50,0,0},
      '{0,'h555,'hAA,0,0}, '{0,'h2AA,'h55,0,0}, '{0,0,'hF0,0,0}, '{0,'h555,'h50,0,0},
      '{1,'h1800,0,'hFFFF,0}, '{0,'h555,'hAA,0,0}, '{0,'h2AA,'h55,0,0},
      '{0,'h555,'h50,0,1}, '{1,0,0,'hFFFE,1}};
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    check(vol_bits_o, 64'hFFFF_FFFF_FFFF_FFFF);
    check(freeze_o, 1);
    $display("test reset values done");
    // Table of command and read cycles
    foreach (rows[i]) begin
      xfer(rows[i].rd, rows[i].a, rows[i].d);
      if (rows[i].rd) check(q, rows[i].e);
      check(mode_o, rows[i].m);
    end
    check(vol_bits_o, 64'hFFFF_FFFF_FFFF_FFFF);
    check(freeze_o, 0);
    $display("test command table done");
    // Reset in mid-run, inside the lock space
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    check(mode_o, 0);
    check(freeze_o, 1);
    xfer(1, 24'h000100, 16'h0000);
    check(q, 16'hFFFF);
    $display("test mid-run reset done");
    // Sector set with stray high address bit and upper data byte set
    xfer(0, 24'h000555, 16'h00AA);
    xfer(0, 24'h0002AA, 16'h0055);
    xfer(0, 24'h000555, 16'h00E0);
    check(mode_o, 2);
    xfer(0, 24'h000000, 16'h00A0);
    xfer(0, 24'h0229C3, 16'hFF00);
    check(vol_bits_o, 64'hFFFF_FFFF_FFFF_FFDF);
    check(freeze_o, 1);
    xfer(1, 24'h002800, 16'h0000);
    check(q, 16'hFFFE);
    xfer(1, 24'h003000, 16'h0000);
    check(q, 16'hFFFF);
    xfer(0, 24'h000000, 16'h00F0);
    check(mode_o, 0);
    check(vol_bits_o, 64'hFFFF_FFFF_FFFF_FFDF);
    $display("test sector address decode done");
    conclude;
  end
endmodule

// File: spd_checker.sv
`timescale 1ns/1ps
// ****************************************
// Link checker between host and device
// ****************************************
module spd_checker #(
  parameter int AW = 24
) (
  input wire logic          mclk_i,
  input wire logic          rst_i,
  input wire logic          ck,
  input wire logic          cs_n,
  input wire logic          rd,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0]   wdata,
  input wire logic [15:0]   rdata,
  input wire logic          rds
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Read cycle launched by a rising link clock
  sequence rd_launch;
    rd && !cs_n && $rose(ck);
  endsequence
  // Link clock high phase of four clocks
  sequence ck_pulse;
    ck [*4] ##1 !ck;
  endsequence

  chk_ck_idle_low: assert property (cs_n |-> !ck)
    else $error("link clock high while deselected");
  chk_ck_high_len: assert property ($rose(ck) |-> ck_pulse)
    else $error("link clock high phase length wrong");
  chk_cmd_stable: assert property (ck |-> $stable(addr) && $stable(wdata) && $stable(rd))
    else $error("command changed while link clock high");
  chk_cmd_setup: assert property ($rose(ck) |-> $past(addr, 3) == addr)
    else $error("address setup too short");
  chk_rd_answer: assert property (rd_launch |-> ##[2:8] rds)
    else $error("read strobe missing");
  chk_rds_cause: assert property ($rose(rds) |-> rd && !cs_n)
    else $error("read strobe without read cycle");
  chk_rdata_hold: assert property (rds && $past(rds) |-> $stable(rdata))
    else $error("read word changed under strobe");
  chk_cs_release: assert property ($rose(rds) |-> ##[1:6] cs_n)
    else $error("select kept after first word");
  chk_rds_idle: assert property (cs_n [*5] |-> !rds)
    else $error("read strobe stays while deselected");
endmodule

// File: spd_dev.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_dev #(
  parameter int AW      = 24,
  parameter int NSEC    = 64,
  parameter int SEC_LSB = 11
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  spd_link_if.dev                lk,
  input  wire logic [NSEC-1:0]   pers_bits_i,
  output spd_pkg::spd_mode_e     mode_o,
  output logic      [NSEC-1:0]   vol_bits_o,
  output logic                   freeze_o
);
  import spd_pkg::*;

  localparam int SW = $clog2(NSEC);

  // ****************************************
  // Link synchronisers
  // ****************************************
  logic          ck_s1_r, ck_s2_r, ck_s3_r;
  logic          cs_s1_r, cs_s2_r;
  logic          rd_s1_r, rd_s2_r;
  logic [AW-1:0] ad_s1_r, ad_s2_r;
  logic [15:0]   wd_s1_r, wd_s2_r;

  // Two flops on every pin, third flop for edge find
  always_ff @(posedge mclk_i) begin
    ck_s1_r <= lk.ck;
    ck_s2_r <= ck_s1_r;
    ck_s3_r <= ck_s2_r;
    cs_s1_r <= lk.cs_n;
    cs_s2_r <= cs_s1_r;
    rd_s1_r <= lk.rd;
    rd_s2_r <= rd_s1_r;
    ad_s1_r <= lk.addr;
    ad_s2_r <= ad_s1_r;
    wd_s1_r <= lk.wdata;
    wd_s2_r <= wd_s1_r;
  end

  // ****************************************
  // Cycle decode
  // ****************************************
  logic                 bus_edge;
  logic                 wr_ev;
  logic                 rd_ev;
  logic [`SPD_CA_W-1:0] cmd_a;
  logic [`SPD_CD_W-1:0] cmd_d;
  logic [SW-1:0]        sec;
  logic                 at_555;
  logic                 d_is_zero;
  logic                 d_is_one;

  // Rising link clock with select low is one bus cycle
  assign bus_edge  = ck_s2_r & ~ck_s3_r & ~cs_s2_r;
  assign wr_ev     = bus_edge & ~rd_s2_r;
  assign rd_ev     = bus_edge & rd_s2_r;
  assign cmd_a     = ad_s2_r[`SPD_CA_W-1:0];
  assign cmd_d     = wd_s2_r[`SPD_CD_W-1:0];
  assign sec       = ad_s2_r[SEC_LSB +: SW];
  assign at_555    = (cmd_a == `SPD_A_555);
  assign d_is_zero = (cmd_d == `SPD_D_ZERO);
  assign d_is_one  = (cmd_d == `SPD_D_ONE);

  // ****************************************
  // Sequence and mode state
  // ****************************************
  spd_mode_e mode_r, mode_nxt;
  spd_seq_e  seq_r, seq_nxt;
  logic      in_space;

  assign in_space = (mode_r != MD_ARRAY);

  // Next mode and sequence step per write or read
  always_comb begin
    mode_nxt = mode_r;
    seq_nxt  = seq_r;
    if (wr_ev) begin
      seq_nxt = SQ_IDLE;
      if (cmd_d == `SPD_D_RESET) begin
        mode_nxt = MD_ARRAY;
      end else begin
        unique case (seq_r)
          SQ_IDLE: begin
            if (!in_space && at_555 && cmd_d == `SPD_D_AA) begin
              seq_nxt = SQ_UNL1;
            end else if (in_space && cmd_d == `SPD_D_EXIT) begin
              seq_nxt = SQ_EXIT;
            end else if ((mode_r == MD_LOCK || mode_r == MD_VOL) &&
                         cmd_d == `SPD_D_PROG) begin
              seq_nxt = SQ_PROG;
            end else if (mode_r == MD_VOL && cmd_d == `SPD_D_QUERY) begin
              seq_nxt = SQ_QRY;
            end
          end
          SQ_UNL1: begin
            if (cmd_a == `SPD_A_2AA && cmd_d == `SPD_D_55) begin
              seq_nxt = SQ_UNL2;
            end
          end
          SQ_UNL2: begin
            if (at_555 && cmd_d == `SPD_D_LOCK) begin
              mode_nxt = MD_LOCK;
            end else if (at_555 && cmd_d == `SPD_D_VOL) begin
              mode_nxt = MD_VOL;
            end else if (at_555 && cmd_d == `SPD_D_ECC) begin
              mode_nxt = MD_ECC;
            end
          end
          SQ_EXIT: begin
            if (d_is_zero) begin
              mode_nxt = MD_ARRAY;
            end
          end
          SQ_PROG: seq_nxt = SQ_IDLE;
          SQ_QRY:  seq_nxt = SQ_IDLE;
        endcase
      end
    end else if (rd_ev && seq_r == SQ_QRY) begin
      seq_nxt = SQ_IDLE;
    end
  end

  // Unknown commands such as suspend, password or mode-lock program fall
  // to the drop path, leave the mode as it was and return the sequence to idle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_r <= MD_ARRAY;
      seq_r  <= SQ_IDLE;
    end else begin
      mode_r <= mode_nxt;
      seq_r  <= seq_nxt;
    end
  end

  // ****************************************
  // Protection bits
  // ****************************************
  logic [NSEC-1:0] vol_r;
  logic            frz_r;
  logic            prog_cyc;

  assign prog_cyc = wr_ev & (seq_r == SQ_PROG) & (cmd_d != `SPD_D_RESET);

  // Second write after A0 acts on freeze or sector bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vol_r <= {NSEC{`SPD_VOL_RST}};
      frz_r <= `SPD_FRZ_RST;
    end else begin
      if (prog_cyc && mode_r == MD_LOCK && d_is_zero) begin
        frz_r <= 1'b0;
      end
      if (prog_cyc && mode_r == MD_VOL && d_is_zero) begin
        vol_r[sec] <= 1'b0;
      end else if (prog_cyc && mode_r == MD_VOL && d_is_one) begin
        vol_r[sec] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] rword;
  logic [15:0] rdat_r;
  logic        rds_r;
  logic        first_r;
  logic        vbit;
  logic        pbit;

  assign vbit = vol_r[sec];
  assign pbit = pers_bits_i[sec];

  // Word selected by current space and pending query
  always_comb begin
    rword = `SPD_ERASED;
    if (first_r) begin
      rword = `SPD_UNDEF;
    end else if (seq_r == SQ_QRY) begin
      rword = {`SPD_ONES13, pbit, vbit, pbit & vbit};
    end else begin
      unique case (mode_r)
        MD_ARRAY: rword = `SPD_ERASED;
        MD_LOCK:  rword = {`SPD_ONES15, frz_r};
        MD_VOL:   rword = {`SPD_ONES15, vbit};
        MD_ECC:   rword = `SPD_ECC_STAT;
      endcase
    end
  end

  // Strobe stays up until select is released
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdat_r  <= `SPD_ERASED;
      rds_r   <= 1'b0;
      first_r <= 1'b0;
    end else if (cs_s2_r) begin
      rds_r   <= 1'b0;
      first_r <= 1'b0;
    end else if (rd_ev) begin
      rdat_r  <= rword;
      rds_r   <= 1'b1;
      first_r <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [NSEC-1:0] vol_o_r;
  logic            frz_o_r;
  spd_mode_e       mode_o_r;

  // Registered status copies for the user side
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vol_o_r  <= {NSEC{`SPD_VOL_RST}};
      frz_o_r  <= `SPD_FRZ_RST;
      mode_o_r <= MD_ARRAY;
    end else begin
      vol_o_r  <= vol_r;
      frz_o_r  <= frz_r;
      mode_o_r <= mode_r;
    end
  end

  assign lk.rdata   = rdat_r;
  assign lk.rds     = rds_r;
  assign vol_bits_o = vol_o_r;
  assign freeze_o   = frz_o_r;
  assign mode_o     = mode_o_r;
endmodule

// File: spd_hst.sv
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_hst #(
  parameter int AW   = 24,
  parameter int HALF = `SPD_HALF_CYC
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  spd_link_if.hst            lk,
  input  wire logic          cmd_valid_i,
  input  wire logic          cmd_rd_i,
  input  wire logic [AW-1:0] cmd_addr_i,
  input  wire logic [15:0]   cmd_data_i,
  output logic               cmd_ready_o,
  output logic               rsp_valid_o,
  output logic [15:0]        rsp_data_o
);
  import spd_pkg::*;

  localparam logic [`SPD_CNT_W-1:0] HLAST = `SPD_CNT_W'(HALF - 1);

  // ****************************************
  // Read-back synchronisers
  // ****************************************
  logic        rds_s1_r, rds_s2_r;
  logic [15:0] rd_s1_r, rd_s2_r;

  always_ff @(posedge mclk_i) begin
    rds_s1_r <= lk.rds;
    rds_s2_r <= rds_s1_r;
    rd_s1_r  <= lk.rdata;
    rd_s2_r  <= rd_s1_r;
  end

  // ****************************************
  // Cycle sequencer and clock divider
  // ****************************************
  spd_hst_e             st_r;
  logic [`SPD_CNT_W-1:0] cnt_r;
  logic                 ck_r, cs_n_r, rd_r, rdy_r, rv_r;
  logic [AW-1:0]        ad_r;
  logic [15:0]          wd_r, rsp_r;
  logic                 cnt_done;

  assign cnt_done = (cnt_r == '0);

  // One word per select, link clock is mclk divided by 2*HALF
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r   <= HS_IDLE;
      cnt_r  <= '0;
      ck_r   <= 1'b0;
      cs_n_r <= 1'b1;
      rd_r   <= 1'b0;
      ad_r   <= '0;
      wd_r   <= '0;
      rdy_r  <= 1'b1;
      rv_r   <= 1'b0;
      rsp_r  <= '0;
    end else begin
      rv_r  <= 1'b0;
      cnt_r <= cnt_done ? cnt_r : cnt_r - 1'b1;
      unique case (st_r)
        HS_IDLE: begin
          if (cmd_valid_i) begin
            cs_n_r <= 1'b0;
            rd_r   <= cmd_rd_i;
            ad_r   <= cmd_addr_i;
            wd_r   <= cmd_data_i;
            rdy_r  <= 1'b0;
            cnt_r  <= HLAST;
            st_r   <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (cnt_done) begin
            ck_r  <= 1'b1;
            cnt_r <= HLAST;
            st_r  <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (cnt_done) begin
            ck_r  <= 1'b0;
            cnt_r <= HLAST;
            if (rd_r) begin
              st_r <= HS_WAIT;
            end else begin
              cs_n_r <= 1'b1;
              st_r   <= HS_GAP;
            end
          end
        end
        HS_WAIT: begin
          if (rds_s2_r) begin
            rsp_r  <= rd_s2_r;
            rv_r   <= 1'b1;
            cs_n_r <= 1'b1;
            cnt_r  <= HLAST;
            st_r   <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (cnt_done && !rds_s2_r) begin
            rdy_r <= 1'b1;
            st_r  <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign lk.ck       = ck_r;
  assign lk.cs_n     = cs_n_r;
  assign lk.rd       = rd_r;
  assign lk.addr     = ad_r;
  assign lk.wdata    = wd_r;
  assign cmd_ready_o = rdy_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o  = rsp_r;
endmodule

// File: spd_link_if.sv
`timescale 1ns/1ps
// ****************************************
// Word link between host and device
// ****************************************
interface spd_link_if #(parameter int AW = 24);
  logic          ck;
  logic          cs_n;
  logic          rd;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;
  logic          rds;

  modport dev (input ck, cs_n, rd, addr, wdata, output rdata, rds);
  modport hst (output ck, cs_n, rd, addr, wdata, input rdata, rds);
endinterface

// File: spd_map.svh
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
// Functional notes
// - AA@555, 55@2AA, 50@555 enters lock space
// - In lock space, A0 then 00 clears freeze
// - Lock space read returns freeze bit in bit0
// - Leave spaces with 90,00 or single F0
// - AA@555, 55@2AA, E0@555 enters volatile space
// - A0 then sector write: 00 sets, 01 clears
// - Bit status read: bit0 state, bits 15:1 high
// - 60 then sector read gives three protection bits
// - Only first read word per select is valid
// - Values hex, addresses count 16-bit words
// - Upper data byte ignored in command cycles
// - Address bits 11 and up ignored in commands
// - Command cycles are writes except listed reads
// - Array reads need no command cycles
// - Reset command returns device to array read
// - Suspend and resume only when erase allows
// - Abort state needs full abort-reset sequence
// - Password portions one per A0, ascending
// - Both mode-lock bits together aborts to read
// - Sector address decodes bits 16 down to 11
// - Identification and query entries share data
// - AA@555, 55@2AA, 75@555 enters ECC space

// ****************************************
// Command cycle addresses and data
// ****************************************
`define SPD_CA_W      11
`define SPD_CD_W      8
`define SPD_A_555     11'h555
`define SPD_A_2AA     11'h2AA
`define SPD_D_AA      8'hAA
`define SPD_D_55      8'h55
`define SPD_D_LOCK    8'h50
`define SPD_D_VOL     8'hE0
`define SPD_D_ECC     8'h75
`define SPD_D_PROG    8'hA0
`define SPD_D_EXIT    8'h90
`define SPD_D_ZERO    8'h00
`define SPD_D_ONE     8'h01
`define SPD_D_QUERY   8'h60
`define SPD_D_RESET   8'hF0

// ****************************************
// Read words and reset values
// ****************************************
`define SPD_ERASED    16'hFFFF
`define SPD_UNDEF     16'hFFFF
`define SPD_ECC_STAT  16'h0000
`define SPD_ONES15    15'h7FFF
`define SPD_ONES13    13'h1FFF
`define SPD_FRZ_RST   1'b1
`define SPD_VOL_RST   1'b1

// ****************************************
// Link timing
// ****************************************
`define SPD_MCLK_NS   25
`define SPD_LK_NS     200
`define SPD_HALF_CYC  ((`SPD_LK_NS / `SPD_MCLK_NS) / 2)
`define SPD_CNT_W     8
`endif

// File: spd_pkg.sv
package spd_pkg;
  // Decoder address space
  typedef enum logic [1:0] {MD_ARRAY, MD_LOCK, MD_VOL, MD_ECC} spd_mode_e;
  // Position inside a command sequence
  typedef enum logic [2:0] {SQ_IDLE, SQ_UNL1, SQ_UNL2, SQ_PROG, SQ_EXIT, SQ_QRY} spd_seq_e;
  // Host link sequencer
  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_HIGH, HS_WAIT, HS_GAP} spd_hst_e;
endpackage
